// file: hdl/scirc_pkg.sv
// package: constants and types for the system-control interrupt and reset-cause block
package scirc_pkg;
  // ****************************************
  // sizes
  // ****************************************
  localparam int NUM_EV = 7;
  localparam int NUM_RC = 6;
  localparam int AW     = 12;

  // ****************************************
  // register byte offsets
  // ****************************************
  localparam logic [11:0] OFS_BOCTL = 12'h030;
  localparam logic [11:0] OFS_RAW   = 12'h050;
  localparam logic [11:0] OFS_MASK  = 12'h054;
  localparam logic [11:0] OFS_MIS   = 12'h058;
  localparam logic [11:0] OFS_CAUSE = 12'h05C;

  // ****************************************
  // event bit positions
  // ****************************************
  localparam int EV_PLL_STOP   = 0;
  localparam int EV_BROWNOUT   = 1;
  localparam int EV_REG_UNREG  = 2;
  localparam int EV_MAIN_OSC   = 3;
  localparam int EV_INT_OSC    = 4;
  localparam int EV_CUR_LIMIT  = 5;
  localparam int EV_LOCK_READY = 6;

  // ****************************************
  // reset-cause bit positions
  // ****************************************
  localparam int RC_PIN       = 0;
  localparam int RC_POWER_ON  = 1;
  localparam int RC_BROWNOUT  = 2;
  localparam int RC_WATCHDOG  = 3;
  localparam int RC_SOFTWARE  = 4;
  localparam int RC_REGULATOR = 5;

  // brown-out control: interrupt-versus-reset selector position
  localparam int BO_SEL_POS = 1;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [6:0]  RAW_RST   = 7'h00;
  localparam logic [6:0]  MASK_RST  = 7'h00;
  localparam logic        BOSEL_RST = 1'h0;
  localparam logic [5:0]  PIN_ONLY  = 6'h01;
  localparam logic [31:0] RD_ZERO   = 32'h0000_0000;

  // ****************************************
  // bus carriers
  // ****************************************
  typedef struct packed {
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic        hready;
  } scirc_ahb_in_t;

  typedef struct packed {
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
  } scirc_ahb_out_t;
endpackage

// file: hdl/scirc_top.sv
// module: system-control masked interrupt status, event flags and reset-cause register
//
// Behaviour
// (R01) each masked status bit is raw flag AND mask (bit 1 also needs the selector cleared), and their OR is the interrupt line.
// (R02) writing one to a masked status bit clears it and its raw flag, zero leaves both.
// (R03) bit 6 sets when the pll ready-settling timer expires, if its mask is set.
// (R04) bit 5 sets when the regulator current-limit indication asserts, if masked in.
// (R05) bit 4 sets when an internal oscillator fault is detected, if masked in.
// (R06) bit 3 sets when a main oscillator fault is detected, if masked in.
// (R07) bit 2 sets when the regulator output goes unregulated, if masked in.
// (R08) bit 1 reports only with its mask set and the brown-out selector cleared.
// (R09) bit 0 sets when the pll stops oscillating, if masked in.
// (R10) unused upper bits read as don't-care and software keeps them on writes.
// (R11) the reset-cause register has no fixed reset value but reflects the reset source.
// (R12) a pin reset sets bit 0 and clears all other cause bits.
// (R13) any other reset source except power-on sets its bit and keeps earlier bits set.
// (R14) cause bit 5 is regulator power-good loss, bit 4 software, bit 3 watchdog.
// (R15) cause bit 2 is brown-out, bit 1 power-on, bit 0 the external pin.
// (R16) a set mask bit lets its raw flag raise the interrupt, a clear one blocks it.
// (R17) software may write the cause bits and the value stays until the next reset.
`timescale 1ns/1ps
module scirc_top #(
  parameter int EV_W = 7,
  parameter int RC_W = 6
) (
  input  wire logic                      mclk,
  input  wire logic                      rstn,
  input  wire scirc_pkg::scirc_ahb_in_t  ahb_in,
  output scirc_pkg::scirc_ahb_out_t      ahb_out,
  input  wire logic [EV_W-1:0]           event_det,
  input  wire logic [RC_W-1:0]           reset_src,
  output logic                           sysctl_irq
);
  import scirc_pkg::*;

  // ****************************************
  // elaboration checks
  // ****************************************
  if (EV_W != NUM_EV) begin : g_chk_ev
    $error("event width must match the status layout");
  end
  if (RC_W != NUM_RC) begin : g_chk_rc
    $error("reset source width must match the cause layout");
  end

  // ****************************************
  // declarations
  // ****************************************
  logic [EV_W-1:0] ev_s1;
  logic [EV_W-1:0] ev_s2;
  logic [EV_W-1:0] ev_s3;
  logic [EV_W-1:0] ev_rise;
  logic [RC_W-1:0] rs_s1;
  logic [RC_W-1:0] rs_s2;
  logic [EV_W-1:0] raw_event_flags;
  logic [EV_W-1:0] event_mask_reg;
  logic [EV_W-1:0] gate;
  logic [EV_W-1:0] masked;
  logic            brownout_irq_not_reset_sel;
  logic [RC_W-1:0] reset_cause_reg;
  logic            ap_take;
  logic            dp_wr;
  logic [AW-1:0]   dp_addr;
  logic            wr_any;
  logic            wr_mask;
  logic            wr_mis;
  logic            wr_cause;
  logic            wr_boctl;
  logic [31:0]     next_rdata;
  logic [31:0]     rdata;

  // ****************************************
  // input synchronisers
  // ****************************************

  // detector levels cross into mclk, second and third stages feed the edge detect
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      ev_s1 <= '0;
      ev_s2 <= '0;
      ev_s3 <= '0;
    end else begin
      ev_s1 <= event_det;
      ev_s2 <= ev_s1;
      ev_s3 <= ev_s2;
    end
  end

  // a detector going active is one event
  assign ev_rise = ev_s2 & ~ev_s3;

  // reset sources keep running during reset so the cause can be caught
  always_ff @(posedge mclk) begin
    rs_s1 <= reset_src;
    rs_s2 <= rs_s1;
  end

  // ****************************************
  // ahb-lite slave
  // ****************************************

  // address phase accepted on a selected nonsequential or sequential transfer with hready high, busy is not taken
  assign ap_take = ahb_in.hsel & ahb_in.htrans[1] & ahb_in.hready;

  // address phase registered for the write data phase
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      dp_wr   <= 1'b0;
      dp_addr <= '0;
    end else if (ahb_in.hready) begin
      dp_wr   <= ap_take & ahb_in.hwrite;
      dp_addr <= ahb_in.haddr[AW-1:0];
    end
  end

  // write strobes per register, unmapped writes fall through
  assign wr_any   = dp_wr & ahb_in.hready;
  assign wr_mask  = wr_any & (dp_addr == OFS_MASK);
  assign wr_mis   = wr_any & (dp_addr == OFS_MIS);
  assign wr_cause = wr_any & (dp_addr == OFS_CAUSE);
  assign wr_boctl = wr_any & (dp_addr == OFS_BOCTL);

  // read mux, reserved bits and unmapped offsets read zero
  always_comb begin
    next_rdata = RD_ZERO;
    case (ahb_in.haddr[AW-1:0])
      OFS_RAW:   next_rdata[EV_W-1:0] = raw_event_flags;
      OFS_MASK:  next_rdata[EV_W-1:0] = event_mask_reg;
      OFS_MIS:   next_rdata[EV_W-1:0] = masked; // R01
      OFS_CAUSE: next_rdata[RC_W-1:0] = reset_cause_reg;
      OFS_BOCTL: next_rdata[BO_SEL_POS] = brownout_irq_not_reset_sel;
      default:   next_rdata = RD_ZERO; // R10
    endcase
  end

  // read data captured at the address phase, stands until the next read
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      rdata <= RD_ZERO;
    end else if (ap_take & ~ahb_in.hwrite) begin
      rdata <= next_rdata;
    end
  end

  // zero wait states, always okay
  assign ahb_out.hrdata    = rdata;
  assign ahb_out.hreadyout = 1'b1;
  assign ahb_out.hresp     = 1'b0;

  // ****************************************
  // mask and brown-out control
  // ****************************************

  // mask register, upper write bits dropped
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      event_mask_reg <= MASK_RST;
    end else if (wr_mask) begin
      event_mask_reg <= ahb_in.hwdata[EV_W-1:0]; // R10
    end
  end

  // brown-out interrupt-versus-reset selector
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      brownout_irq_not_reset_sel <= BOSEL_RST;
    end else if (wr_boctl) begin
      brownout_irq_not_reset_sel <= ahb_in.hwdata[BO_SEL_POS];
    end
  end

  // ****************************************
  // raw flags and masked status
  // ****************************************

  // per bit: event sets, write-one clears, set wins the same cycle
  for (genvar i = 0; i < EV_W; i++) begin : g_raw
    always_ff @(posedge mclk) begin
      if (!rstn) begin
        raw_event_flags[i] <= RAW_RST[i];
      end else if (ev_rise[i]) begin
        raw_event_flags[i] <= 1'b1; // R03 R04 R05 R06 R07 R09
      end else if (wr_mis & ahb_in.hwdata[i]) begin
        raw_event_flags[i] <= 1'b0; // R02
      end
    end
  end

  // mask gating, brown-out also needs the selector cleared
  always_comb begin
    gate = event_mask_reg; // R16
    gate[EV_BROWNOUT] = event_mask_reg[EV_BROWNOUT] & ~brownout_irq_not_reset_sel; // R08
  end

  // masked status and the single level interrupt
  assign masked     = raw_event_flags & gate; // R01
  assign sysctl_irq = |masked; // R01

  // ****************************************
  // reset cause
  // ****************************************

  // caught while reset is held; no fixed value, the source decides
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      if (rs_s2[RC_PIN]) begin
        reset_cause_reg <= PIN_ONLY; // R11 R12 R15
      end else if (rs_s2[RC_POWER_ON]) begin
        reset_cause_reg <= rs_s2; // R11 R15
      end else begin
        reset_cause_reg <= reset_cause_reg | rs_s2; // R13 R14
      end
    end else if (wr_cause) begin
      reset_cause_reg <= ahb_in.hwdata[RC_W-1:0]; // R17
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  logic            last_in_rst;
  logic            last_pin;
  logic            last_pwr;
  logic [RC_W-1:0] last_src;
  logic [RC_W-1:0] last_cause;

  // helper copies of the last cycle of reset
  always_ff @(posedge mclk) begin
    last_in_rst <= ~rstn;
    last_pin    <= rs_s2[RC_PIN];
    last_pwr    <= rs_s2[RC_POWER_ON];
    last_src    <= rs_s2;
    last_cause  <= reset_cause_reg;
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  property p_irq_and;
    sysctl_irq == |(raw_event_flags & event_mask_reg &
                    ~(EV_W'(brownout_irq_not_reset_sel) << EV_BROWNOUT));
  endproperty
  a_irq_and: assert property (p_irq_and) else $error("irq not and of flags and mask"); // R01

  property p_clr_lock;
    wr_mis && ahb_in.hwdata[EV_LOCK_READY] && !ev_rise[EV_LOCK_READY]
      |=> !raw_event_flags[EV_LOCK_READY] && !masked[EV_LOCK_READY];
  endproperty
  a_clr_lock: assert property (p_clr_lock) else $error("write one did not clear"); // R02

  property p_zero_keeps;
    wr_mis && !ahb_in.hwdata[EV_CUR_LIMIT] && raw_event_flags[EV_CUR_LIMIT]
      |=> raw_event_flags[EV_CUR_LIMIT];
  endproperty
  a_zero_keeps: assert property (p_zero_keeps) else $error("write zero cleared a flag"); // R02

  property p_set_wins;
    ev_rise[EV_INT_OSC] && wr_mis && ahb_in.hwdata[EV_INT_OSC]
      |=> raw_event_flags[EV_INT_OSC];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("event lost to clear"); // R05

  property p_det_irq;
    $rose(ev_s2[EV_MAIN_OSC]) && event_mask_reg[EV_MAIN_OSC] && !wr_mask
      |=> masked[EV_MAIN_OSC] && sysctl_irq;
  endproperty
  a_det_irq: assert property (p_det_irq) else $error("masked event gave no irq"); // R06

  property p_bo_sel;
    brownout_irq_not_reset_sel |-> !masked[EV_BROWNOUT];
  endproperty
  a_bo_sel: assert property (p_bo_sel) else $error("brown-out reported in reset mode"); // R08

  property p_mask_off;
    !event_mask_reg[EV_PLL_STOP] |-> !masked[EV_PLL_STOP];
  endproperty
  a_mask_off: assert property (p_mask_off) else $error("unmasked bit leaked"); // R16

  property p_cause_pin;
    last_in_rst && last_pin |-> reset_cause_reg == PIN_ONLY;
  endproperty
  a_cause_pin: assert property (p_cause_pin) else $error("pin reset cause wrong"); // R12

  property p_cause_acc;
    last_in_rst && !last_pin && !last_pwr |-> reset_cause_reg == (last_cause | last_src);
  endproperty
  a_cause_acc: assert property (p_cause_acc) else $error("causes did not accumulate"); // R13

  property p_cause_wr;
    wr_cause ##1 !wr_cause[*2] |-> reset_cause_reg == $past(ahb_in.hwdata[RC_W-1:0], 2);
  endproperty
  a_cause_wr: assert property (p_cause_wr) else $error("cause write not kept"); // R17

  property p_rd_mis;
    ap_take && !ahb_in.hwrite && ahb_in.haddr[AW-1:0] == OFS_MIS
      |=> rdata == {{(32-EV_W){1'b0}}, $past(masked)};
  endproperty
  a_rd_mis: assert property (p_rd_mis) else $error("status read mismatch"); // R01

  c_irq_rise:  cover property ($rose(sysctl_irq));
  c_irq_clear: cover property (sysctl_irq ##1 wr_mis ##1 !sysctl_irq);
  c_pin_rst:   cover property (last_in_rst && last_pin);
  c_accum:     cover property (last_in_rst && !last_pin && !last_pwr && last_cause != '0);
endmodule

// file: dv/scirc_det_model.sv
// detector model: turns one-cycle triggers into three-cycle event levels
`timescale 1ns/1ps
module scirc_det_model (
  input  wire logic       mclk,
  input  wire logic [6:0] trig,
  output logic [6:0]      event_det
);
  logic [6:0] d1, d2, d3;
  // level falls again so that every trigger is a fresh rising edge
  always_ff @(posedge mclk) begin
    d1 <= trig;
    d2 <= d1;
    d3 <= d2;
  end
  assign event_det = d1 | d2 | d3;
endmodule

// file: dv/sysctl_irq_status_reset_cause_bench.sv
// bench: register, event, interrupt and reset-cause tests for scirc_top
`timescale 1ns/1ps
module sysctl_irq_status_reset_cause_bench;
  import scirc_pkg::*;
  logic                  mclk = 1'b0;
  logic                  rstn = 1'b0;
  logic                  sel = 1'b0;
  logic                  w = 1'b0;
  logic [1:0]            tr = 2'h0;
  logic [31:0]           a = 32'h0;
  logic [31:0]           wd = 32'h0;
  logic [6:0]            trig = 7'h00;
  logic [5:0]            rsrc = 6'h01;
  logic [6:0]            event_det;
  logic                  sysctl_irq;
  scirc_ahb_in_t         ahb_in;
  scirc_ahb_out_t        ahb_out;
  int                    bad_count = 0;
  int                    checks = 0;
  int                    cyc = 0;
  localparam int         LIMIT = 4000;
  logic [31:0]           rdv;
  logic [5:0]            srcs [6] = '{6'h08, 6'h10, 6'h20, 6'h04, 6'h09, 6'h02};
  logic [5:0]            exps [6] = '{6'h08, 6'h18, 6'h38, 6'h3C, 6'h01, 6'h02};

  // ****************************************
  // clock, bus wiring, instances
  // ****************************************
  always #2.5 mclk = ~mclk;
  assign ahb_in = '{hsel: sel, haddr: a, htrans: tr, hwrite: w, hsize: 3'h2,
                    hwdata: wd, hready: ahb_out.hreadyout};
  scirc_top u_scirc_top (.mclk(mclk), .rstn(rstn), .ahb_in(ahb_in), .ahb_out(ahb_out),
    .event_det(event_det), .reset_src(rsrc), .sysctl_irq(sysctl_irq));
  scirc_det_model u_scirc_det_model (.mclk(mclk), .trig(trig), .event_det(event_det));

  // ****************************************
  // tasks
  // ****************************************
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // one single transfer: address phase, then data phase
  task automatic xfer(input logic [11:0] ad, input logic wr, input logic [31:0] d);
    @(posedge mclk);
    sel <= 1'b1; tr <= 2'h2; a <= {20'h0, ad}; w <= wr;
    do @(posedge mclk); while (ahb_out.hreadyout !== 1'b1);
    sel <= 1'b0; tr <= 2'h0; wd <= d;
    do @(posedge mclk); while (ahb_out.hreadyout !== 1'b1);
    rdv = ahb_out.hrdata;
  endtask

  task automatic wr(input logic [11:0] ad, input logic [31:0] d);
    xfer(ad, 1'b1, d);
  endtask

  // read one register and compare, response must be okay
  task automatic chk(input logic [11:0] ad, input logic [31:0] exp);
    xfer(ad, 1'b0, 32'h0000_0000);
    checks = checks + 1;
    if (rdv !== exp || ahb_out.hresp !== 1'b0) begin
      bad_count = bad_count + 1;
      $display("BAD %0t read %h got %h want %h", $time, ad, rdv, exp);
    end
  endtask

  // interrupt level looked at mid-cycle where it has settled
  task automatic chk_irq(input logic exp);
    @(negedge mclk);
    checks = checks + 1;
    if (sysctl_irq !== exp) begin
      bad_count = bad_count + 1;
      $display("BAD %0t irq got %b want %b", $time, sysctl_irq, exp);
    end
  endtask

  // one trigger per detector bit, then wait past the synchroniser
  task automatic pulse(input logic [6:0] b);
    @(posedge mclk);
    trig <= b;
    @(posedge mclk);
    trig <= 7'h00;
    repeat (6) @(posedge mclk);
  endtask

  // reset held four edges so the synchronised source reaches the cause register
  task automatic do_reset(input logic [5:0] s);
    @(posedge mclk);
    rsrc <= s;
    rstn <= 1'b0;
    repeat (4) @(posedge mclk);
    rstn <= 1'b1;
    rsrc <= 6'h00;
  endtask

  // ****************************************
  // timeout
  // ****************************************
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      bad_count = bad_count + 1;
      $display("BAD %0t timeout", $time);
      report_and_stop();
    end
  end

  // ****************************************
  // tests
  // ****************************************
  initial begin
    repeat (4) @(posedge mclk);
    rstn <= 1'b1;
    rsrc <= 6'h00;
    chk(OFS_MIS, 32'h0000_0000);
    chk(OFS_CAUSE, 32'h0000_0001);
    chk_irq(1'b0);
    // masked out event: raw set, status and irq stay low
    pulse(7'h01);
    chk(OFS_RAW, 32'h0000_0001);
    chk(OFS_MIS, 32'h0000_0000);
    chk_irq(1'b0);
    wr(OFS_MASK, 32'h0000_007F);
    chk(OFS_MASK, 32'h0000_007F);
    chk(OFS_MIS, 32'h0000_0001);
    chk_irq(1'b1);
    // write zero keeps, write one clears status and raw
    wr(OFS_MIS, 32'h0000_0000);
    chk(OFS_MIS, 32'h0000_0001);
    wr(OFS_MIS, 32'h0000_0001);
    chk(OFS_RAW, 32'h0000_0000);
    chk(OFS_MIS, 32'h0000_0000);
    chk_irq(1'b0);
    // lock, current limit, oscillator and regulator events
    pulse(7'h7C);
    chk(OFS_MIS, 32'h0000_007C);
    chk_irq(1'b1);
    wr(OFS_MIS, 32'h0000_007C);
    chk(OFS_MIS, 32'h0000_0000);
    // brown-out in reset mode is not reported
    wr(OFS_BOCTL, 32'h0000_0002);
    pulse(7'h02);
    chk(OFS_RAW, 32'h0000_0002);
    chk(OFS_MIS, 32'h0000_0000);
    chk_irq(1'b0);
    wr(OFS_BOCTL, 32'h0000_0000);
    chk(OFS_MIS, 32'h0000_0002);
    chk_irq(1'b1);
    wr(OFS_MIS, 32'h0000_0002);
    chk_irq(1'b0);
    // cause register is writable and keeps the value
    wr(OFS_CAUSE, 32'h0000_003F);
    chk(OFS_CAUSE, 32'h0000_003F);
    wr(OFS_CAUSE, 32'h0000_0000);
    chk(OFS_CAUSE, 32'h0000_0000);
    // successive resets: accumulate, pin clears, power-on restarts
    for (int i = 0; i < 6; i++) begin
      do_reset(srcs[i]);
      chk(OFS_CAUSE, {26'h0, exps[i]});
    end
    chk(OFS_MASK, 32'h0000_0000);
    chk_irq(1'b0);
    report_and_stop();
  end
endmodule
